// >>> include/dac_ctl_pkg.sv
// Constants and carriers for the DAC output state control block.
// Assumes a single 20 MHz clock domain and a plain register port.
package dac_ctl_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 24;
    localparam int CODE_W = 18;

    // Register indices (byte address = index, plain port)
    localparam logic [3:0] ADDR_DAC = 4'h1;
    localparam logic [3:0] ADDR_CTRL = 4'h2;
    localparam logic [3:0] ADDR_CLEARCODE = 4'h3;
    localparam logic [3:0] ADDR_SWCTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;

    // Control register field positions
    localparam int CTRL_FBR_BIT = 1;
    localparam int CTRL_CLAMP_BIT = 2;
    localparam int CTRL_TRI_BIT = 3;
    localparam int CTRL_FMT_BIT = 4;

    // Software pulse control field positions
    localparam int SW_LOAD_BIT = 0;
    localparam int SW_CLEAR_BIT = 1;
    localparam int SW_RESET_BIT = 2;

    // Code field position inside the 24-bit data word
    localparam int CODE_LSB = 2;

    // Reset values
    localparam logic [17:0] CODE_RESET = 18'h00000;
    localparam logic CLAMP_RESET = 1'b1;
    localparam logic TRI_RESET = 1'b1;
    localparam logic FMT_RESET = 1'b0;
    localparam logic FBR_RESET = 1'b0;
    localparam logic [23:0] RDATA_RESET = 24'h000000;

    // Output state of the analog stage
    typedef enum logic [1:0] {
        OUT_NORMAL,
        OUT_TRISTATE,
        OUT_CLAMPED
    } out_state_e;

    // Control fields carried together
    typedef struct packed {
        logic fmt_offset_bin;
        logic dac_tristate;
        logic output_ground_clamp;
        logic feedback_resistor_buffer;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '{
        fmt_offset_bin: FMT_RESET,
        dac_tristate: TRI_RESET,
        output_ground_clamp: CLAMP_RESET,
        feedback_resistor_buffer: FBR_RESET
    };

endpackage : dac_ctl_pkg

// >>> hw/dac_output_state_control.sv
// DAC output state control: registers, one-shot functions, output state.
// Assumes a host on the plain register port in the mclk domain and an
// external load-update pin from outside that domain (synchronised here).
//
// The implementer's own choices: the address-and-strobe port and the address map.

// What this block does
// - Load function copies input value to DAC
// - Clear function loads clear code, updates output
// - Reset function restores power-on state
// - Power-on sets all registers to defaults
// - Power-on: core tristated, output clamped to ground
// - Only control write releases power-on condition
// - Clearing both bits enters normal mode
// - Released output shows reset DAC value
// - Output state decoded from two bits
// - Clamp set keeps core tristated regardless
// - Format bit zero twos complement, one offset
// - Clear ignored while load pin low
module dac_output_state_control (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [23:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [23:0] rdata,
    input wire logic load_update_pin_n,
    output logic [17:0] dac_code,
    output logic [1:0] out_state,
    output logic core_tristate,
    output logic ground_clamp,
    output logic feedback_resistor_buffer,
    output logic code_format_select
);

    logic ld_meta_q;
    logic ld_sync_q;
    logic [17:0] input_q;
    logic [17:0] dac_q;
    logic [17:0] clear_code_q;
    dac_ctl_pkg::ctrl_s ctrl_q;
    dac_ctl_pkg::ctrl_s ctrl_d;
    dac_ctl_pkg::out_state_e state_q;
    logic core_tri_q;
    logic clamp_q;
    logic [23:0] rdata_q;
    logic wr_ctrl;
    logic wr_sw;
    logic sw_load;
    logic sw_clear;
    logic sw_reset;
    logic [17:0] wcode;

    // Extract the 18-bit code field from a data word
    function automatic logic [17:0] code_of(input logic [23:0] w);
        code_of = w[dac_ctl_pkg::CODE_LSB +: dac_ctl_pkg::CODE_W];
    endfunction : code_of

    // Place an 18-bit code into a data word
    function automatic logic [23:0] word_of(input logic [17:0] c);
        word_of = {4'h0, c, 2'h0};
    endfunction : word_of

    // Address decode; function bits are not stored anywhere
    assign wr_ctrl = wr_stb && (addr == dac_ctl_pkg::ADDR_CTRL);
    assign wr_sw = wr_stb && (addr == dac_ctl_pkg::ADDR_SWCTRL);
    assign sw_load = wr_sw && wdata[dac_ctl_pkg::SW_LOAD_BIT];
    assign sw_clear = wr_sw && wdata[dac_ctl_pkg::SW_CLEAR_BIT];
    assign sw_reset = wr_sw && wdata[dac_ctl_pkg::SW_RESET_BIT];
    assign wcode = code_of(wdata);

    // Two-stage synchroniser for the external load-update pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ld_meta_q <= 1'b1;
            ld_sync_q <= 1'b1;
        end else begin
            ld_meta_q <= load_update_pin_n;
            ld_sync_q <= ld_meta_q;
        end
    end

    // Pending input value, written by the host
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            input_q <= dac_ctl_pkg::CODE_RESET;
        end else if (sw_reset) begin
            input_q <= dac_ctl_pkg::CODE_RESET;
        end else if (wr_stb && addr == dac_ctl_pkg::ADDR_DAC) begin
            input_q <= wcode;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clear_code_q <= dac_ctl_pkg::CODE_RESET;
        end else if (sw_reset) begin
            clear_code_q <= dac_ctl_pkg::CODE_RESET;
        end else if (wr_stb && addr == dac_ctl_pkg::ADDR_CLEARCODE) begin
            clear_code_q <= wcode;
        end
    end

    // DAC register; reset content maps to midscale in the reset twos complement format.
    // Reset beats clear beats load when several bits share one write.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dac_q <= dac_ctl_pkg::CODE_RESET;
        end else if (sw_reset) begin
            dac_q <= dac_ctl_pkg::CODE_RESET;
        end else if (sw_clear && ld_sync_q) begin
            dac_q <= clear_code_q;
        end else if (sw_load) begin
            dac_q <= input_q;
        end
    end

    // Next control value from a control write
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d.fmt_offset_bin = wdata[dac_ctl_pkg::CTRL_FMT_BIT];
            ctrl_d.dac_tristate = wdata[dac_ctl_pkg::CTRL_TRI_BIT];
            ctrl_d.output_ground_clamp = wdata[dac_ctl_pkg::CTRL_CLAMP_BIT];
            ctrl_d.feedback_resistor_buffer =
                wdata[dac_ctl_pkg::CTRL_FBR_BIT];
        end
    end

    // Control register; only a control write or a soft reset changes it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= dac_ctl_pkg::CTRL_RESET;
        end else if (sw_reset) begin
            ctrl_q <= dac_ctl_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Output state decode, registered so outputs come from flops.
    // Computed from ctrl_d so the state follows the register exactly.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= dac_ctl_pkg::OUT_CLAMPED;
            core_tri_q <= 1'b1;
            clamp_q <= 1'b1;
        end else if (sw_reset) begin
            state_q <= dac_ctl_pkg::OUT_CLAMPED;
            core_tri_q <= 1'b1;
            clamp_q <= 1'b1;
        end else if (ctrl_d.output_ground_clamp) begin
            state_q <= dac_ctl_pkg::OUT_CLAMPED;
            core_tri_q <= 1'b1;
            clamp_q <= 1'b1;
        end else if (ctrl_d.dac_tristate) begin
            state_q <= dac_ctl_pkg::OUT_TRISTATE;
            core_tri_q <= 1'b1;
            clamp_q <= 1'b0;
        end else begin
            state_q <= dac_ctl_pkg::OUT_NORMAL;
            core_tri_q <= 1'b0;
            clamp_q <= 1'b0;
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    // Software control is write only and reads as zero.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= dac_ctl_pkg::RDATA_RESET;
        end else if (rd_stb) begin
            unique case (addr)
                dac_ctl_pkg::ADDR_DAC: rdata_q <= word_of(dac_q);
                dac_ctl_pkg::ADDR_CLEARCODE: rdata_q <= word_of(clear_code_q);
                dac_ctl_pkg::ADDR_CTRL: begin
                    rdata_q <= dac_ctl_pkg::RDATA_RESET;
                    rdata_q[dac_ctl_pkg::CTRL_FMT_BIT] <= ctrl_q.fmt_offset_bin;
                    rdata_q[dac_ctl_pkg::CTRL_TRI_BIT] <= ctrl_q.dac_tristate;
                    rdata_q[dac_ctl_pkg::CTRL_CLAMP_BIT] <=
                        ctrl_q.output_ground_clamp;
                    rdata_q[dac_ctl_pkg::CTRL_FBR_BIT] <=
                        ctrl_q.feedback_resistor_buffer;
                end
                dac_ctl_pkg::ADDR_STATUS: rdata_q <= {22'h000000, state_q};
                default: rdata_q <= dac_ctl_pkg::RDATA_RESET;
            endcase
        end else begin
            rdata_q <= dac_ctl_pkg::RDATA_RESET;
        end
    end

    // Outputs straight from flip-flops
    assign rdata = rdata_q;
    assign dac_code = dac_q;
    assign out_state = state_q;
    assign core_tristate = core_tri_q;
    assign ground_clamp = clamp_q;
    assign feedback_resistor_buffer = ctrl_q.feedback_resistor_buffer;
    assign code_format_select = ctrl_q.fmt_offset_bin;

endmodule : dac_output_state_control

// >>> tb/host_model.sv
// Host model: drives the plain register port from the far side.
// Assumes one mclk domain; every change follows a rising edge.
module host_model (
    input wire logic mclk,
    output logic [3:0] addr,
    output logic [23:0] wdata,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [23:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus from time zero
    initial begin
        addr = 4'h0;
        wdata = 24'h000000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    // One-cycle write; released lines show the inverse, not a stale value
    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : wr
    // One-cycle read; data taken in the cycle after the strobe only
    task automatic rd(input logic [3:0] a, output logic [23:0] d);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        d = rdata;
    endtask : rd
endmodule : host_model

// >>> tb/dac_state_sva.sv
// Checker for the DAC output state control block, top-level ports only.
// Assumes one mclk domain and the asynchronous active-low reset.
module dac_state_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [23:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [23:0] rdata,
    input wire logic load_update_pin_n,
    input wire logic [17:0] dac_code,
    input wire logic [1:0] out_state,
    input wire logic core_tristate,
    input wire logic ground_clamp,
    input wire logic feedback_resistor_buffer,
    input wire logic code_format_select
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Decoded writes to control and function registers
    wire ctl_wr = wr_stb && addr == dac_ctl_pkg::ADDR_CTRL;
    wire sw_wr = wr_stb && addr == dac_ctl_pkg::ADDR_SWCTRL;
    chk_state_decode: assert property (
        out_state == (ground_clamp ? 2'h2 : core_tristate ? 2'h1 : 2'h0))
        else $error("output state not decoded from clamp and tristate");
    chk_clamp_forces_tri: assert property (
        ground_clamp |-> core_tristate)
        else $error("clamp set without core tristate");
    chk_ctrl_fields: assert property (
        ctl_wr |=> ground_clamp == $past(wdata[2])
        && core_tristate == ($past(wdata[3]) | $past(wdata[2]))
        && feedback_resistor_buffer == $past(wdata[1])
        && code_format_select == $past(wdata[4]))
        else $error("control write not reflected");
    chk_state_hold: assert property (
        !ctl_wr && !sw_wr |=> $stable(out_state))
        else $error("output state changed without a write");
    chk_rdata_idle: assert property (!rd_stb |=> rdata == 24'h000000)
        else $error("read data outside its cycle");
    chk_code_hold: assert property (!wr_stb |=> $stable(dac_code))
        else $error("DAC code changed without a write");
    chk_soft_reset: assert property (
        sw_wr && wdata[2] |-> ##[1:2] (ground_clamp && core_tristate
        && dac_code == 18'h00000 && !feedback_resistor_buffer))
        else $error("soft reset did not restore power-on state");
    chk_clear_gated: assert property (
        !load_update_pin_n [*3] ##0 (sw_wr && wdata[2:0] == 3'h2)
        |=> $stable(dac_code))
        else $error("clear acted while load pin low");
endmodule : dac_state_chk

bind dac_output_state_control dac_state_chk chk (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .load_update_pin_n(load_update_pin_n), .dac_code(dac_code),
    .out_state(out_state), .core_tristate(core_tristate),
    .ground_clamp(ground_clamp),
    .feedback_resistor_buffer(feedback_resistor_buffer),
    .code_format_select(code_format_select));

// >>> tb/testbench.sv
// Self-checking bench for the DAC output state control block.
// Assumes host_model on the register port and the bound checker.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic pin_n = 1'b1;
    logic [3:0] addr;
    logic [23:0] wdata, rdata, rd_val;
    logic wr_stb, rd_stb, fbr, fmt, tri_o, clamp;
    logic [17:0] code;
    logic [1:0] st;
    int fails = 0;
    int tests_run = 0;
    // All outputs but rdata in one word: code, state, tristate, clamp, fbr, format
    wire [23:0] snap = {code, st, tri_o, clamp, fbr, fmt};
    localparam logic [23:0] POWER_ON = 24'h00002c;
    host_model host (.mclk(mclk), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
    dac_output_state_control uut (.mclk(mclk), .reset_n(reset_n),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .load_update_pin_n(pin_n), .dac_code(code),
        .out_state(st), .core_tristate(tri_o), .ground_clamp(clamp),
        .feedback_resistor_buffer(fbr), .code_format_select(fmt));
    initial forever #25 mclk = ~mclk;
    // Hang guard
    initial begin
        repeat (4000) @(posedge mclk);
        fails++;
        give_verdict();
    end
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : cmp
    // Write, then let the edge's updates land
    task automatic w(input logic [3:0] a, input logic [23:0] d);
        host.wr(a, d);
        @(negedge mclk);
    endtask : w
    task automatic t_power();
        @(negedge mclk);
        cmp(snap, POWER_ON);
        host.rd(4'h0, rd_val);
        cmp(rd_val, 24'h000000);
        host.rd(dac_ctl_pkg::ADDR_SWCTRL, rd_val);
        cmp(rd_val, 24'h000000);
        host.rd(dac_ctl_pkg::ADDR_STATUS, rd_val);
        cmp(rd_val, 24'h000002);
    endtask : t_power
    // Every tristate and clamp pairing, fbr and format alongside
    task automatic t_states();
        for (int i = 0; i < 4; i++) begin
            w(dac_ctl_pkg::ADDR_CTRL, {19'h0, i[1], i[0], i[1], i[0], 1'b0});
            cmp(snap, {18'h0, i[1] ? 2'h2 : {1'b0, i[0]}, i[0] | i[1],
                i[1], i[0], i[1]});
        end
        w(dac_ctl_pkg::ADDR_CTRL, 24'h000000);
    endtask : t_states
    task automatic t_load();
        w(dac_ctl_pkg::ADDR_DAC, {4'h0, 18'h2a5c3, 2'h0});
        cmp(snap, 24'h000000);
        w(dac_ctl_pkg::ADDR_SWCTRL, 24'h000001);
        cmp(snap, {18'h2a5c3, 6'h00});
        host.rd(dac_ctl_pkg::ADDR_DAC, rd_val);
        cmp(rd_val, {4'h0, 18'h2a5c3, 2'h0});
        w(dac_ctl_pkg::ADDR_SWCTRL, 24'h000000);
        cmp(snap, {18'h2a5c3, 6'h00});
    endtask : t_load
    task automatic t_clear();
        w(dac_ctl_pkg::ADDR_CLEARCODE, {4'h0, 18'h3ffff, 2'h0});
        w(dac_ctl_pkg::ADDR_SWCTRL, 24'h000002);
        cmp(snap, {18'h3ffff, 6'h00});
        @(posedge mclk);
        pin_n <= 1'b0;
        repeat (3) @(posedge mclk);
        w(dac_ctl_pkg::ADDR_DAC, {4'h0, 18'h00011, 2'h0});
        w(dac_ctl_pkg::ADDR_SWCTRL, 24'h000002);
        cmp(snap, {18'h3ffff, 6'h00});
        w(dac_ctl_pkg::ADDR_SWCTRL, 24'h000001);
        cmp(snap, {18'h00011, 6'h00});
        @(posedge mclk);
        pin_n <= 1'b1;
    endtask : t_clear
    // Soft reset; effect may land one edge late, so allow that edge
    task automatic t_sreset();
        w(dac_ctl_pkg::ADDR_CTRL, 24'h000012);
        cmp(snap, {18'h00011, 6'h03});
        host.rd(dac_ctl_pkg::ADDR_CTRL, rd_val);
        cmp(rd_val, 24'h000012);
        w(dac_ctl_pkg::ADDR_SWCTRL, 24'h000004);
        @(negedge mclk);
        cmp(snap, POWER_ON);
        w(dac_ctl_pkg::ADDR_SWCTRL, 24'h000001);
        cmp(snap, POWER_ON);
    endtask : t_sreset
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // Reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        t_power();
        t_states();
        t_load();
        t_clear();
        t_sreset();
        give_verdict();
    end
endmodule : testbench
